// ### core/fmip_mod_path.sv
`timescale 1ns/1ps
`include "fmip_cfg.svh"
module fmip_mod_path
  import fmip_pkg::*;
(
  input  wire logic                       mclk,
  input  wire logic                       rst,
  input  wire logic                       slotStart,
  input  wire fmip_slot_t                 carrierSlot,
  input  wire logic [`FMIP_SEL_W-1:0]     modXSourceSelect,
  input  wire logic [`FMIP_SEL_W-1:0]     modYSourceSelect,
  input  wire fmip_depth_t                modulationDepth,
  input  wire logic [`FMIP_STEP_W-1:0]    pitchStep,
  input  wire logic                       phaseClear,
  input  wire logic                       sampleValid,
  input  wire fmip_slot_t                 sampleSlot,
  input  wire fmip_sample_t               sampleData,
  output logic                            readValid,
  output fmip_slot_t                      readSlot,
  output fmip_addr_t                      readAddr,
  output fmip_offset_t                    modOffset,
  output fmip_sample_t                    averagedModValue,
  output logic                            clipped
);
  // ***************************************************************
  // Selector decode
  // ***************************************************************
  fmip_sel_s  xSel;
  fmip_sel_s  ySel;
  fmip_slot_t xModSlot;
  fmip_slot_t yModSlot;

  // Selectors are fields: generation bit over a relative offset
  assign xSel = fmip_sel_s'(modXSourceSelect); // RULE3
  assign ySel = fmip_sel_s'(modYSourceSelect); // RULE3

  // Offset adds to the carrier and wraps at 32 slots
  always_comb begin
    xModSlot = fmip_slot_t'(carrierSlot + xSel.offset); // RULE1
    yModSlot = fmip_slot_t'(carrierSlot + ySel.offset); // RULE1
  end

  // ***************************************************************
  // Sound stack
  // ***************************************************************
  fmip_stack_if stk ();

  // Exactly two reads per carrier, X then Y
  assign stk.rdSlot[0]   = xModSlot; // RULE12
  assign stk.rdSlot[1]   = yModSlot; // RULE12
  assign stk.rdNewest[0] = xSel.newest;
  assign stk.rdNewest[1] = ySel.newest;

  // Any slot may feed back, itself included, since reads go via the stack
  fmip_sound_stack u_stack (
    .mclk   (mclk),
    .rst    (rst),
    .wrEn   (sampleValid), // RULE15
    .wrSlot (sampleSlot),
    .wrData (sampleData),
    .rd     (stk.stack) // RULE13
  );

  // ***************************************************************
  // Stage one: fetched samples
  // ***************************************************************
  logic                    s1Valid_q;
  logic                    s1Valid_d;
  fmip_slot_t              s1Slot_q;
  fmip_slot_t              s1Slot_d;
  fmip_depth_t             s1Depth_q;
  fmip_depth_t             s1Depth_d;
  logic [`FMIP_STEP_W-1:0] s1Step_q;
  logic [`FMIP_STEP_W-1:0] s1Step_d;
  logic                    s1Clear_q;
  logic                    s1Clear_d;
  fmip_sample_t            xInputSample_q;
  fmip_sample_t            xInputSample_d;
  fmip_sample_t            yInputSample_q;
  fmip_sample_t            yInputSample_d;

  // Settings are captured with the samples so they may change freely after
  always_comb begin
    s1Valid_d      = slotStart;
    s1Slot_d       = s1Slot_q;
    s1Depth_d      = s1Depth_q;
    s1Step_d       = s1Step_q;
    s1Clear_d      = s1Clear_q;
    xInputSample_d = xInputSample_q;
    yInputSample_d = yInputSample_q;
    if (slotStart) begin
      s1Slot_d       = carrierSlot;
      s1Depth_d      = modulationDepth;
      s1Step_d       = pitchStep;
      s1Clear_d      = phaseClear;
      xInputSample_d = stk.rdData[0]; // RULE13
      yInputSample_d = stk.rdData[1]; // RULE13
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s1Valid_q      <= 1'b0;
      s1Slot_q       <= '0;
      s1Depth_q      <= '0;
      s1Step_q       <= '0;
      s1Clear_q      <= 1'b0;
      xInputSample_q <= `FMIP_SAMPLE_RST;
      yInputSample_q <= `FMIP_SAMPLE_RST;
    end else begin
      s1Valid_q      <= s1Valid_d;
      s1Slot_q       <= s1Slot_d;
      s1Depth_q      <= s1Depth_d;
      s1Step_q       <= s1Step_d;
      s1Clear_q      <= s1Clear_d;
      xInputSample_q <= xInputSample_d;
      yInputSample_q <= yInputSample_d;
    end
  end

  // ***************************************************************
  // Averaging and depth scaling
  // ***************************************************************
  fmip_sample_t avgNow;
  fmip_offset_t shiftNow;
  logic         clipNow;

  // Depth A maps full scale to 1024 words, still inside the range
  fmip_depth_scale u_scale (
    .xSample    (xInputSample_q), // RULE4
    .ySample    (yInputSample_q), // RULE4
    .depth      (s1Depth_q), // RULE6
    .avgValue   (avgNow),
    .shiftValue (shiftNow), // RULE9
    .clipped    (clipNow)
  );

  // ***************************************************************
  // Per-slot phase accumulators
  // ***************************************************************
  fmip_phase_t phase_q [`FMIP_NUM_SLOTS];
  fmip_phase_t phase_d [`FMIP_NUM_SLOTS];
  fmip_phase_t curPhase;
  fmip_addr_t  phaseInt;

  assign curPhase = phase_q[s1Slot_q];
  assign phaseInt = curPhase[`FMIP_PHASE_W-1:`FMIP_PHASE_FRAC];

  // Phase grows by pitch alone; modulation never feeds back into it
  always_comb begin
    for (int i = 0; i < `FMIP_NUM_SLOTS; i++) begin
      phase_d[i] = phase_q[i];
    end
    if (s1Valid_q) begin
      if (s1Clear_q) begin
        phase_d[s1Slot_q] = `FMIP_PHASE_RST;
      end else begin
        phase_d[s1Slot_q] = fmip_phase_t'(curPhase + {10'h000, s1Step_q}); // RULE8
      end
    end
  end

  always_ff @(posedge mclk) begin
    for (int i = 0; i < `FMIP_NUM_SLOTS; i++) begin
      if (rst) begin
        phase_q[i] <= `FMIP_PHASE_RST;
      end else begin
        phase_q[i] <= phase_d[i];
      end
    end
  end

  // ***************************************************************
  // Stage two: read address out
  // ***************************************************************
  logic         readValid_q;
  logic         readValid_d;
  fmip_slot_t   readSlot_q;
  fmip_slot_t   readSlot_d;
  fmip_addr_t   readAddr_q;
  fmip_addr_t   readAddr_d;
  fmip_offset_t modOffset_q;
  fmip_offset_t modOffset_d;
  fmip_sample_t avg_q;
  fmip_sample_t avg_d;
  logic         clip_q;
  logic         clip_d;

  // Address is the unmodulated phase plus the signed shift, wrapping
  always_comb begin
    readValid_d = s1Valid_q;
    readSlot_d  = readSlot_q;
    readAddr_d  = readAddr_q;
    modOffset_d = modOffset_q;
    avg_d       = avg_q;
    clip_d      = clip_q;
    if (s1Valid_q) begin
      readSlot_d  = s1Slot_q;
      modOffset_d = shiftNow;
      avg_d       = avgNow;
      clip_d      = clipNow;
      if (s1Clear_q) begin
        readAddr_d = fmip_addr_t'({{5{shiftNow[`FMIP_OFFSET_W-1]}}, shiftNow}); // RULE5
      end else begin
        readAddr_d = fmip_addr_t'(phaseInt + {{5{shiftNow[`FMIP_OFFSET_W-1]}}, shiftNow}); // RULE5
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      readValid_q <= 1'b0;
      readSlot_q  <= '0;
      readAddr_q  <= '0;
      modOffset_q <= '0;
      avg_q       <= `FMIP_SAMPLE_RST;
      clip_q      <= 1'b0;
    end else begin
      readValid_q <= readValid_d;
      readSlot_q  <= readSlot_d;
      readAddr_q  <= readAddr_d;
      modOffset_q <= modOffset_d;
      avg_q       <= avg_d;
      clip_q      <= clip_d;
    end
  end

  assign readValid        = readValid_q;
  assign readSlot         = readSlot_q;
  assign readAddr         = readAddr_q;
  assign modOffset        = modOffset_q;
  assign averagedModValue = avg_q;
  assign clipped          = clip_q;
endmodule

// ### core/fmip_cfg.svh
// What this block does
// RULE1: Selector low five bits give modulator slot minus carrier slot, modulo 32.
// RULE2: Sound stack holds output samples of slots 0 to 31, carrier included.
// RULE3: Selectors are 6 bits; top bit picks newest or previous generation.
// RULE4: Modulation value is the X sample plus the Y sample, divided by two.
// RULE5: Depth scales the averaged value; result offsets the phase read address.
// RULE6: Depth 0 to 4 gives no shift; 5 to F give 32 up to 32768.
// RULE7: Peak shift only at full-scale average; smaller values shift proportionally.
// RULE8: With zero offset the read phase advances only by the pitch step.
// RULE9: Shifts up to 1K words, depth A, pass without clipping.
// RULE10: Shifts beyond 1K words in magnitude are forced back to zero.
// RULE11: Applied offset keeps only ten valid address bits plus sign.
// RULE12: Each slot has exactly two modulation inputs and one output.
// RULE13: Sources come from the sound stack, allowing self and multi-stage feedback.
// RULE14: Software keeps three cycles of wave data around each FM waveform.
// RULE15: Each slot output becomes newest stack entry; old newest becomes previous.
`ifndef FMIP_CFG_SVH
`define FMIP_CFG_SVH

// ***************************************************************
// Widths and counts
// ***************************************************************
`define FMIP_NUM_SLOTS    32
`define FMIP_SLOT_W       5
`define FMIP_SAMPLE_W     16
`define FMIP_SEL_W        6
`define FMIP_SEL_GEN_BIT  5
`define FMIP_DEPTH_W      4
`define FMIP_OFFSET_W     11
`define FMIP_PHASE_W      26
`define FMIP_PHASE_FRAC   10
`define FMIP_STEP_W       16
`define FMIP_ADDR_W       16

// ***************************************************************
// Scaling and clipping
// ***************************************************************
`define FMIP_DEPTH_MIN    4'h5
`define FMIP_FULL_SHIFT   15
`define FMIP_SHIFT_HI     32'sh000003ff
`define FMIP_SHIFT_LO     -32'sh00000400

// ***************************************************************
// Reset values
// ***************************************************************
`define FMIP_SAMPLE_RST   16'h0000
`define FMIP_PHASE_RST    26'h0000000

`endif

// ### core/fmip_pkg.sv
`include "fmip_cfg.svh"
package fmip_pkg;
  typedef logic        [`FMIP_SLOT_W-1:0]   fmip_slot_t;
  typedef logic signed [`FMIP_SAMPLE_W-1:0] fmip_sample_t;
  typedef logic        [`FMIP_DEPTH_W-1:0]  fmip_depth_t;
  typedef logic signed [`FMIP_OFFSET_W-1:0] fmip_offset_t;
  typedef logic        [`FMIP_PHASE_W-1:0]  fmip_phase_t;
  typedef logic        [`FMIP_ADDR_W-1:0]   fmip_addr_t;
  typedef struct packed {
    logic       newest;
    fmip_slot_t offset;
  } fmip_sel_s;
endpackage

// ### core/fmip_stack_if.sv
`timescale 1ns/1ps
// Two read ports into the sound stack, X at index 0 and Y at index 1
interface fmip_stack_if;
  import fmip_pkg::*;
  fmip_slot_t   [1:0] rdSlot;
  logic         [1:0] rdNewest;
  fmip_sample_t [1:0] rdData;
  modport stack (
    input  rdSlot,
    input  rdNewest,
    output rdData
  );
  modport user (
    output rdSlot,
    output rdNewest,
    input  rdData
  );
endinterface

// ### core/fmip_sound_stack.sv
`timescale 1ns/1ps
`include "fmip_cfg.svh"
module fmip_sound_stack
  import fmip_pkg::*;
(
  input  wire logic         mclk,
  input  wire logic         rst,
  input  wire logic         wrEn,
  input  wire fmip_slot_t   wrSlot,
  input  wire fmip_sample_t wrData,
  fmip_stack_if.stack       rd
);
  // ***************************************************************
  // Two generations per slot
  // ***************************************************************
  fmip_sample_t newest_q [`FMIP_NUM_SLOTS]; // RULE2
  fmip_sample_t newest_d [`FMIP_NUM_SLOTS];
  fmip_sample_t prev_q   [`FMIP_NUM_SLOTS];
  fmip_sample_t prev_d   [`FMIP_NUM_SLOTS];

  // Write shifts newest into previous for that slot only
  always_comb begin
    for (int i = 0; i < `FMIP_NUM_SLOTS; i++) begin
      newest_d[i] = newest_q[i];
      prev_d[i]   = prev_q[i];
    end
    if (wrEn) begin
      prev_d[wrSlot]   = newest_q[wrSlot]; // RULE15
      newest_d[wrSlot] = wrData; // RULE15
    end
  end

  always_ff @(posedge mclk) begin
    for (int i = 0; i < `FMIP_NUM_SLOTS; i++) begin
      if (rst) begin
        newest_q[i] <= `FMIP_SAMPLE_RST;
        prev_q[i]   <= `FMIP_SAMPLE_RST;
      end else begin
        newest_q[i] <= newest_d[i];
        prev_q[i]   <= prev_d[i];
      end
    end
  end

  // ***************************************************************
  // Read ports
  // ***************************************************************
  // Reads see the stored value; a same-cycle write lands one edge later
  for (genvar p = 0; p < 2; p++) begin : g_rd
    assign rd.rdData[p] = rd.rdNewest[p] ? newest_q[rd.rdSlot[p]] : prev_q[rd.rdSlot[p]]; // RULE3
  end
endmodule

// ### core/fmip_depth_scale.sv
`timescale 1ns/1ps
`include "fmip_cfg.svh"
module fmip_depth_scale
  import fmip_pkg::*;
(
  input  wire fmip_sample_t xSample,
  input  wire fmip_sample_t ySample,
  input  wire fmip_depth_t  depth,
  output fmip_sample_t      avgValue,
  output fmip_offset_t      shiftValue,
  output logic              clipped
);
  logic signed [`FMIP_SAMPLE_W:0] pairSum;
  logic signed [31:0]             wide;
  logic signed [31:0]             scaled;

  // ***************************************************************
  // Average, scale, clip
  // ***************************************************************
  // Sum kept one bit wider so the halving never overflows
  always_comb begin
    pairSum  = 17'(xSample) + 17'(ySample);
    avgValue = pairSum[`FMIP_SAMPLE_W:1]; // RULE4
    wide     = 32'(avgValue) <<< depth; // RULE7
    scaled   = wide >>> `FMIP_FULL_SHIFT; // RULE5
    if (depth < `FMIP_DEPTH_MIN) begin
      scaled = 32'sh0; // RULE6
    end
    // Ten magnitude bits only, so an out of range shift is zeroed
    clipped    = (scaled > `FMIP_SHIFT_HI) || (scaled < `FMIP_SHIFT_LO); // RULE10
    shiftValue = clipped ? '0 : scaled[`FMIP_OFFSET_W-1:0]; // RULE11
  end
endmodule

// ### tb/fmip_sample_src.sv
`timescale 1ns/1ps
module fmip_sample_src
  import fmip_pkg::*;
(
  input  wire logic         mclk,
  input  wire logic         cmdValid,
  input  wire fmip_slot_t   cmdSlot,
  input  wire fmip_sample_t cmdData,
  output fmip_sample_t      sampleData,
  output fmip_slot_t        sampleSlot,
  output logic              sampleValid
);
  // *****
  // Slot output stage
  // *****
  // Quiet before the first clock
  initial begin
    sampleValid = 1'b0;
    sampleSlot  = '0;
    sampleData  = '0;
  end
  // Finished sample handed to the stack a cycle later; an idle bus toggles so stale data is never trusted
  always @(posedge mclk) begin
    sampleValid <= cmdValid;
    sampleSlot  <= cmdValid ? cmdSlot : ~sampleSlot;
    sampleData  <= cmdValid ? cmdData : ~sampleData;
  end
endmodule

// ### tb/fmip_mod_path_checker.sv
`timescale 1ns/1ps
module fmip_mod_path_checker
  import fmip_pkg::*;
(
  input wire logic         mclk,
  input wire logic         rst,
  input wire logic         slotStart,
  input wire fmip_slot_t   carrierSlot,
  input wire fmip_depth_t  modulationDepth,
  input wire logic         readValid,
  input wire fmip_slot_t   readSlot,
  input wire fmip_addr_t   readAddr,
  input wire fmip_offset_t modOffset,
  input wire fmip_sample_t averagedModValue,
  input wire logic         clipped
);
  fmip_depth_t        dep1_q;
  fmip_depth_t        dep2_q;
  logic signed [31:0] scl;
  logic               fit;
  // *****
  // Helpers and properties
  // *****
  // Depth delayed two edges to meet its result
  always_ff @(posedge mclk) begin
    dep1_q <= modulationDepth;
    dep2_q <= dep1_q;
  end
  // Shift expected from the reported average; only ten bits plus sign survive
  always_comb begin
    scl = (32'(averagedModValue) <<< dep2_q) >>> 15;
    fit = scl <= 1023 && scl >= -1024;
  end
  chk_answer_lat: assert property (@(posedge mclk) disable iff (rst)
    slotStart |-> ##2 readValid) else $error("result late or missing");
  chk_answer_cause: assert property (@(posedge mclk) disable iff (rst)
    readValid |-> $past(slotStart, 2) && !$past(rst, 2)) else $error("result without request");
  chk_slot_follow: assert property (@(posedge mclk) disable iff (rst)
    readValid |-> readSlot == $past(carrierSlot, 2)) else $error("result slot wrong");
  chk_low_depth: assert property (@(posedge mclk) disable iff (rst)
    slotStart && modulationDepth < 4'h5 |-> ##2 modOffset == '0 && !clipped) else $error("low depth shifted");
  chk_clip_flag: assert property (@(posedge mclk) disable iff (rst)
    readValid |-> clipped == (dep2_q >= 4'h5 && !fit)) else $error("clip flag wrong");
  chk_clip_zero: assert property (@(posedge mclk) disable iff (rst)
    readValid && clipped |-> modOffset == '0) else $error("clipped shift not zero");
  chk_shift_value: assert property (@(posedge mclk) disable iff (rst)
    readValid && !clipped |-> modOffset == (dep2_q < 4'h5 ? 11'h0 : scl[10:0])) else $error("shift wrong");
  chk_quiet_hold: assert property (@(posedge mclk) disable iff (rst)
    !readValid |-> $stable(readAddr) && $stable(modOffset)) else $error("output moved without result");
  chk_reset_zero: assert property (@(posedge mclk)
    rst |=> !readValid && readAddr == '0 && modOffset == '0) else $error("outputs not cleared by reset");
endmodule
bind fmip_mod_path fmip_mod_path_checker fmip_mod_path_checker_inst (
  .mclk, .rst, .slotStart, .carrierSlot, .modulationDepth, .readValid,
  .readSlot, .readAddr, .modOffset, .averagedModValue, .clipped
);

// ### tb/tb_top.sv
`timescale 1ns/1ps
`define CHK(n, e, a) begin \
  nTests++; \
  if ((a) !== (e)) begin \
    numErrors++; \
    $display("[FAIL] %s exp %h got %h", n, e, a); \
  end \
end
module tb_top;
  import fmip_pkg::*;
  typedef struct packed {
    fmip_slot_t s; fmip_addr_t a; fmip_offset_t o; fmip_sample_t v; logic c;
  } fmip_exp_s;
  logic mclk = 1'b0, rst = 1'b1, slotStart = 1'b0, phaseClear = 1'b0, cmdValid = 1'b0;
  fmip_slot_t carrierSlot = '0, cmdSlot = '0, sampleSlot, readSlot;
  logic [5:0] modXSourceSelect = '0, modYSourceSelect = '0;
  fmip_depth_t modulationDepth = '0;
  logic [15:0] pitchStep = '0;
  fmip_sample_t cmdData = '0, sampleData, averagedModValue, nw[32], pv[32];
  logic sampleValid, readValid, clipped;
  fmip_addr_t readAddr;
  fmip_offset_t modOffset;
  logic [25:0] ph[32];
  fmip_exp_s q[$], ex;
  int numErrors = 0, nTests = 0, i;
  integer seed = 32'h987f;
  logic [31:0] r;
  // *****
  // Harness
  // *****
  fmip_mod_path fmip_mod_path_inst (.mclk, .rst, .slotStart, .carrierSlot, .modXSourceSelect,
    .modYSourceSelect, .modulationDepth, .pitchStep, .phaseClear, .sampleValid, .sampleSlot,
    .sampleData, .readValid, .readSlot, .readAddr, .modOffset, .averagedModValue, .clipped);
  fmip_sample_src fmip_sample_src_inst (.mclk, .cmdValid, .cmdSlot, .cmdData, .sampleData,
    .sampleSlot, .sampleValid);
  initial forever #12.5 mclk = ~mclk;
  task automatic test_done;
    if (numErrors == 0 && nTests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Stack and phases start cleared, as after any reset
  task automatic wipe;
    foreach (nw[j]) begin
      nw[j] = '0;
      pv[j] = '0;
      ph[j] = '0;
    end
    q.delete();
  endtask
  // One cycle of stimulus; the expected result is noted as it is driven
  task automatic cyc(input logic go, input fmip_slot_t c, input logic [5:0] x, input logic [5:0] y,
                     input fmip_depth_t d, input logic clr, input logic wv, input fmip_slot_t ws,
                     input fmip_sample_t wd);
    logic [15:0]        st;
    logic signed [16:0] sm;
    logic signed [31:0] sh;
    fmip_sample_t       av;
    fmip_offset_t       of;
    logic               cl;
    st = 16'($random(seed));
    @(posedge mclk);
    // Write taken at this edge is visible to the request driven now
    if (sampleValid === 1'b1) begin
      pv[sampleSlot] = nw[sampleSlot];
      nw[sampleSlot] = sampleData;
    end
    slotStart <= go;
    carrierSlot <= c;
    modXSourceSelect <= x;
    modYSourceSelect <= y;
    modulationDepth <= d;
    pitchStep <= st;
    phaseClear <= clr;
    cmdValid <= wv;
    cmdSlot <= ws;
    cmdData <= wd;
    if (go) begin
      sm = (x[5] ? nw[c + x[4:0]] : pv[c + x[4:0]]) + (y[5] ? nw[c + y[4:0]] : pv[c + y[4:0]]);
      av = sm[16:1];
      sh = d < 4'h5 ? 0 : (32'(av) <<< d) >>> 15;
      cl = sh > 1023 || sh < -1024;
      of = cl ? '0 : sh[10:0];
      if (clr) ph[c] = '0;
      // Shifted reads land up to 1K words either side; wave memory keeps that margin
      q.push_back('{c, ph[c][25:10] + 16'(of), of, av, cl});
      if (!clr) ph[c] = ph[c] + st;
    end
  endtask
  // Oldest note is matched against each result pulse
  always @(posedge mclk) begin
    if (readValid === 1'b1) begin
      `CHK("result expected", 1'b1, q.size() > 0)
      if (q.size() > 0) begin
        ex = q.pop_front();
        `CHK("readSlot", ex.s, readSlot)
        `CHK("readAddr", ex.a, readAddr)
        `CHK("modOffset", ex.o, modOffset)
        `CHK("averagedModValue", ex.v, averagedModValue)
        `CHK("clipped", ex.c, clipped)
      end
    end
  end
  // Hang guard
  initial begin
    repeat (100000) @(posedge mclk);
    numErrors++;
    test_done();
  end
  initial begin
    wipe();
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    // Two generations in every slot
    for (i = 0; i < 64; i++) cyc(0, 0, 0, 0, 0, 0, 1, i[4:0], 16'($random(seed)));
    // Every selector code, with writes landing meanwhile
    for (i = 0; i < 64; i++) begin
      r = $random(seed);
      cyc(1, r[4:0], i[5:0], r[10:5], r[14:11], 0, 1, r[19:15], r[31:16]);
    end
    // Full-scale self feedback through every depth
    cyc(0, 0, 0, 0, 0, 0, 1, 5'h3, 16'h8000);
    cyc(0, 0, 0, 0, 0, 0, 1, 5'h3, 16'h7fff);
    for (i = 0; i < 16; i++) begin
      cyc(1, 5'h3, 6'h20, 6'h20, i[3:0], 0, 0, 0, 0);
      cyc(1, 5'h3, 6'h00, 6'h00, i[3:0], 0, 0, 0, 0);
    end
    // Same slot back to back, unmodulated
    for (i = 0; i < 8; i++) cyc(1, 5'h5, 0, 0, 4'h0, i == 0, 0, 0, 0);
    // Reset two cycles after a request, once its result has come out
    cyc(1, 5'h7, 6'h21, 6'h3f, 4'ha, 0, 0, 0, 0);
    cyc(0, 0, 0, 0, 0, 0, 0, 0, 0);
    cyc(0, 0, 0, 0, 0, 0, 0, 0, 0);
    rst <= 1'b1;
    repeat (3) @(posedge mclk);
    wipe();
    rst <= 1'b0;
    // Random traffic
    for (i = 0; i < 3000; i++) begin
      r = $random(seed);
      cyc(r[0], r[5:1], r[11:6], r[17:12], r[21:18], r[31:28] == 0, r[22], r[27:23], 16'($random(seed)));
    end
    for (i = 0; i < 20 && q.size() > 0; i++) cyc(0, 0, 0, 0, 0, 0, 0, 0, 0);
    `CHK("pending results", 0, q.size())
    test_done();
  end
endmodule
